/* hdl/moss_pkg.sv */
// Constants for the three-output switch sequencer
package moss_pkg;
  localparam int NUM_CH = 3;
  localparam int CH_W = 2;
  localparam int TV_W = 7;
  localparam int IP_W = 2;
  localparam int EN_W = 3;
  localparam int DRV_W = 2;
  localparam int FAULT_CNT_W = 16;
  // Enable field upper bits: forced on (0b11x), forced off (0b10x)
  localparam logic [1:0] EN_FORCED_ON = 2'h3;
  localparam logic [1:0] EN_FORCED_OFF = 2'h2;
  // Recommended drive strength
  localparam logic [1:0] DRV_RECOMMENDED = 2'h1;
  // Per-channel default of the discharge enable bit
  localparam logic [2:0] DISCHARGE_DEFAULT = 3'h7;
  // Soft-start step time of one target code
  localparam int SS_STEP_NS = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SS_STEP_CYCLES = (SS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SS_CNT_W = 8;
  // Startup fault timeout
  localparam int FAULT_TIMEOUT_US = 100;
  localparam int FAULT_TIMEOUT_CYCLES = FAULT_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  // Sequencer states
  typedef enum logic [2:0] {
    MOSS_IDLE = 3'h1,
    MOSS_CHARGE = 3'h2,
    MOSS_DISCHARGE = 3'h4
  } moss_state_t;
endpackage

/* hdl/moss_soft_start.sv */
// Per-channel soft-start ramp of the target voltage code
`timescale 1ns/100ps
`default_nettype none
module moss_soft_start
(
  input wire logic clock,
  input wire logic rst,
  input wire logic chan_on,
  input wire logic [moss_pkg::TV_W-1:0] target_code,
  output logic [moss_pkg::TV_W-1:0] ramp_code_reg,
  output logic ramp_done
);
  logic [moss_pkg::SS_CNT_W-1:0] step_cnt_reg;
  logic step_tick;

  assign step_tick = (step_cnt_reg == moss_pkg::SS_CNT_W'(moss_pkg::SS_STEP_CYCLES - 1));
  assign ramp_done = (ramp_code_reg == target_code);

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      step_cnt_reg <= 8'h00;
    else if (!chan_on || step_tick)
      step_cnt_reg <= 8'h00;
    else
      step_cnt_reg <= step_cnt_reg + 8'h01;
  end

  // Rises one code per step; falls at once
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      ramp_code_reg <= 7'h00;
    else if (!chan_on)
      ramp_code_reg <= 7'h00;
    else if (ramp_code_reg > target_code)
      ramp_code_reg <= target_code;
    else if (step_tick && !ramp_done)
      ramp_code_reg <= ramp_code_reg + 7'h01;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_ramp_rate: assert property (
    (chan_on && $past(chan_on) && ramp_code_reg > $past(ramp_code_reg))
      |-> (ramp_code_reg == $past(ramp_code_reg) + 7'h01) && $past(step_tick))
    else $error("soft-start ramp rose faster than one code per step");
endmodule
`default_nettype wire

/* hdl/moss_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module moss_sequencer
#(
  parameter logic [15:0] FAULT_TIMEOUT_CYCLES = 16'(moss_pkg::FAULT_TIMEOUT_CYCLES)
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [2:0][6:0] target_voltage_code,
  input wire logic [2:0][1:0] peak_current_limit,
  input wire logic [2:0][2:0] channel_enable_ctrl,
  input wire logic [2:0] discharge_enable,
  input wire logic [2:0] buck_select,
  input wire logic [1:0] gate_drive_strength,
  input wire logic [2:0] fault_clear,
  input wire logic main_bias_on,
  input wire logic supply_uvlo,
  input wire logic [2:0] below_target_cmp,
  input wire logic peak_current_cmp,
  input wire logic zero_cross_detect,
  output logic input_high_switch,
  output logic input_low_switch,
  output logic [2:0] channel_output_switch,
  output logic output_ground_switch,
  output logic [2:0] discharge_switch,
  output logic [1:0] gate_drive_level,
  output logic [1:0] peak_limit_sel,
  output logic [2:0][6:0] ramp_target_code,
  output logic [2:0] fault_flag,
  output logic seq_idle
);
  // Asynchronous analog inputs
  logic [6:0] sync1_reg;
  logic [6:0] sync2_reg;
  logic [2:0] below_sync;
  logic peak_sync;
  logic zx_sync;
  logic bias_sync;
  logic uvlo_sync;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync1_reg <= 7'h00;
      sync2_reg <= 7'h00;
    end
    else
    begin
      sync1_reg <= {supply_uvlo, main_bias_on, zero_cross_detect, peak_current_cmp,
                    below_target_cmp};
      sync2_reg <= sync1_reg;
    end
  end

  assign below_sync = sync2_reg[2:0];
  assign peak_sync = sync2_reg[3];
  assign zx_sync = sync2_reg[4];
  assign bias_sync = sync2_reg[5];
  assign uvlo_sync = sync2_reg[6];

  // Channel on/off and service requests
  logic [2:0] forced_on;
  logic [2:0] chan_on;
  logic [2:0] request;
  logic [2:0] ramp_done;

  always_comb
  begin
    for (int i = 0; i < moss_pkg::NUM_CH; i++)
    begin
      forced_on[i] = (channel_enable_ctrl[i][2:1] == moss_pkg::EN_FORCED_ON);
      chan_on[i] = forced_on[i] ||
                   ((channel_enable_ctrl[i][2:1] != moss_pkg::EN_FORCED_OFF) && bias_sync);
      request[i] = chan_on[i] && below_sync[i];
    end
  end

  genvar g;
  generate
    for (g = 0; g < moss_pkg::NUM_CH; g++)
    begin : gen_ss
      moss_soft_start u_ss
      (
        .clock(clock),
        .rst(rst),
        .chan_on(chan_on[g]),
        .target_code(target_voltage_code[g]),
        .ramp_code_reg(ramp_target_code[g]),
        .ramp_done(ramp_done[g])
      );
    end
  endgenerate

  // Rotating choice: first requester after the last served one
  moss_pkg::moss_state_t state_reg;
  moss_pkg::moss_state_t state_next;
  logic [1:0] cur_ch_reg;
  logic [1:0] pick_ch;
  logic buck_cur_reg;
  logic [1:0] cand;

  always_comb
  begin
    pick_ch = cur_ch_reg;
    cand = 2'h0;
    for (int k = 3; k >= 1; k--)
    begin
      cand = 2'((32'(cur_ch_reg) + k) % moss_pkg::NUM_CH);
      if (request[cand])
        pick_ch = cand;
    end
  end

  always_comb
  begin
    case (state_reg)
      moss_pkg::MOSS_IDLE:
        state_next = (request != 3'h0) ? moss_pkg::MOSS_CHARGE : moss_pkg::MOSS_IDLE;
      moss_pkg::MOSS_CHARGE:
        state_next = peak_sync ? moss_pkg::MOSS_DISCHARGE : moss_pkg::MOSS_CHARGE;
      moss_pkg::MOSS_DISCHARGE:
        state_next = zx_sync ? moss_pkg::MOSS_IDLE : moss_pkg::MOSS_DISCHARGE;
      default:
        state_next = moss_pkg::MOSS_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_reg <= moss_pkg::MOSS_IDLE;
    else
      state_reg <= state_next;
  end

  // Channel and mode latched for the whole cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      cur_ch_reg <= 2'h2;
      buck_cur_reg <= 1'h0;
      peak_limit_sel <= 2'h0;
    end
    else if (state_reg == moss_pkg::MOSS_IDLE && request != 3'h0)
    begin
      cur_ch_reg <= pick_ch;
      buck_cur_reg <= buck_select[pick_ch];
      peak_limit_sel <= peak_current_limit[pick_ch];
    end
  end

  // Switch drive, registered from the next state
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      input_high_switch <= 1'h0;
      input_low_switch <= 1'h0;
      channel_output_switch <= 3'h0;
      output_ground_switch <= 1'h0;
    end
    else
    begin
      input_high_switch <= 1'h0;
      input_low_switch <= 1'h0;
      channel_output_switch <= 3'h0;
      output_ground_switch <= 1'h0;
      case (state_next)
        moss_pkg::MOSS_CHARGE:
        begin
          input_high_switch <= 1'h1;
          if (state_reg == moss_pkg::MOSS_IDLE ? buck_select[pick_ch] : buck_cur_reg)
            channel_output_switch <= 3'h1 << (state_reg == moss_pkg::MOSS_IDLE ?
                                              pick_ch : cur_ch_reg);
          else
            output_ground_switch <= 1'h1;
        end
        moss_pkg::MOSS_DISCHARGE:
        begin
          input_low_switch <= 1'h1;
          channel_output_switch <= 3'h1 << cur_ch_reg;
        end
        default:
        begin
          input_high_switch <= 1'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      seq_idle <= 1'h1;
    else
      seq_idle <= (state_next == moss_pkg::MOSS_IDLE);
  end

  // Drive strength passed to the gate drivers
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      gate_drive_level <= moss_pkg::DRV_RECOMMENDED;
    else
      gate_drive_level <= gate_drive_strength;
  end

  // Active discharge resistor switches
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      discharge_switch <= 3'h0;
    else
      discharge_switch <= (discharge_enable & ~chan_on & ~forced_on)
                          | ({3{uvlo_sync}} & moss_pkg::DISCHARGE_DEFAULT);
  end

  // Startup timeout and sticky fault flags
  logic [2:0][15:0] fault_cnt_reg;
  logic [2:0] reached_reg;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      fault_cnt_reg <= '0;
      reached_reg <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < moss_pkg::NUM_CH; i++)
      begin
        if (!chan_on[i])
        begin
          fault_cnt_reg[i] <= 16'h0000;
          reached_reg[i] <= 1'h0;
        end
        else if (!reached_reg[i])
        begin
          if (ramp_done[i] && !below_sync[i])
            reached_reg[i] <= 1'h1;
          if (fault_cnt_reg[i] != FAULT_TIMEOUT_CYCLES)
            fault_cnt_reg[i] <= fault_cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      fault_flag <= 3'h0;
    else
    begin
      for (int i = 0; i < moss_pkg::NUM_CH; i++)
      begin
        if (chan_on[i] && !reached_reg[i] && fault_cnt_reg[i] == FAULT_TIMEOUT_CYCLES)
          fault_flag[i] <= 1'h1;
        else if (fault_clear[i])
          fault_flag[i] <= 1'h0;
      end
    end
  end

  // Checks
  logic [2:0] req_q;

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      req_q <= 3'h0;
    else
      req_q <= request;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_idle_open: assert property (
    (state_reg == moss_pkg::MOSS_IDLE) |-> !input_high_switch && !input_low_switch
      && channel_output_switch == 3'h0 && !output_ground_switch)
    else $error("switch closed while idle");

  chk_charge_pair: assert property (
    (state_reg == moss_pkg::MOSS_CHARGE && !buck_cur_reg)
      |-> input_high_switch && output_ground_switch && channel_output_switch == 3'h0)
    else $error("buck-boost charge switches wrong");

  chk_peak_exit: assert property (
    (state_reg == moss_pkg::MOSS_CHARGE && peak_sync) |=> state_reg == moss_pkg::MOSS_DISCHARGE)
    else $error("charge did not end at peak trip");

  chk_discharge_path: assert property (
    (state_reg == moss_pkg::MOSS_DISCHARGE) |-> input_low_switch && !input_high_switch
      && !output_ground_switch && channel_output_switch == (3'h1 << cur_ch_reg))
    else $error("discharge switches wrong");

  chk_zx_exit: assert property (
    (state_reg == moss_pkg::MOSS_DISCHARGE && zx_sync) |=> state_reg == moss_pkg::MOSS_IDLE)
    else $error("discharge did not end at zero crossing");

  chk_rotate_fair: assert property (
    (state_reg == moss_pkg::MOSS_IDLE && request[cur_ch_reg]
      && (request & ~(3'h1 << cur_ch_reg)) != 3'h0) |=> cur_ch_reg != $past(cur_ch_reg))
    else $error("same channel served twice while others wait");

  chk_skip_idle: assert property (
    (state_reg == moss_pkg::MOSS_IDLE && request != 3'h0) |=> req_q[cur_ch_reg])
    else $error("non-requesting channel chosen");

  chk_buck_path: assert property (
    (state_reg != moss_pkg::MOSS_IDLE && buck_cur_reg)
      |-> !output_ground_switch && channel_output_switch == (3'h1 << cur_ch_reg))
    else $error("buck service switches wrong");

  chk_forced_nodis: assert property (
    (forced_on[0] && !uvlo_sync) |=> !discharge_switch[0])
    else $error("discharge on while channel forced on");

  chk_uvlo_dis: assert property (
    uvlo_sync |=> discharge_switch == (discharge_switch | moss_pkg::DISCHARGE_DEFAULT))
    else $error("default discharge off during undervoltage");

  chk_fault_sticky: assert property (
    (fault_flag[0] && !fault_clear[0]) |=> fault_flag[0])
    else $error("fault flag dropped without clear");

  cov_bb_cycle: cover property (
    state_reg == moss_pkg::MOSS_CHARGE && !buck_cur_reg ##1 state_reg == moss_pkg::MOSS_DISCHARGE);
  cov_buck_cycle: cover property (state_reg == moss_pkg::MOSS_DISCHARGE && buck_cur_reg);
  cov_fault_set: cover property ($rose(fault_flag[1]));
endmodule
`default_nettype wire

/* sim/moss_switch_stage_model.sv */
// Behavioural switch stage: inductor current phases and comparators
`timescale 1ns/100ps
`default_nettype none
module moss_switch_stage_model
(
  input wire logic clock,
  input wire logic rst,
  input wire logic input_high_switch,
  input wire logic input_low_switch,
  input wire logic [2:0] demand,
  input wire logic slow,
  output logic peak_current_cmp,
  output logic zero_cross_detect,
  output logic [2:0] below_target_cmp
);
  logic [4:0] ramp_reg;
  logic high_reg;
  logic [4:0] span;
  // Clocks the inductor current needs per phase
  assign span = slow ? 5'h0C : 5'h02;
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      ramp_reg <= 5'h00;
      high_reg <= 1'b0;
    end
    else
    begin
      high_reg <= input_high_switch;
      if (input_high_switch != high_reg || !(input_high_switch || input_low_switch))
      begin
        ramp_reg <= 5'h00;
      end
      else if (ramp_reg != 5'h1F)
      begin
        ramp_reg <= ramp_reg + 5'h01;
      end
    end
  end
  // Comparators rest low outside their own phase and until its count reaches span
  assign peak_current_cmp = input_high_switch && high_reg && ramp_reg >= span;
  assign zero_cross_detect = input_low_switch && !high_reg && ramp_reg >= span;
  assign below_target_cmp = demand;
endmodule
`default_nettype wire

/* sim/test_moss_sequencer.sv */
// Self-checking testbench of the three-output switch sequencer
`timescale 1ns/100ps
`default_nettype none
module test_moss_sequencer;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0][6:0] tgt;
  logic [2:0][1:0] lim;
  logic [2:0][2:0] en;
  logic [2:0] de, buck, clr, demand, och, dis, fault, below;
  logic [1:0] drv, drvl, psel;
  logic bias, uvlo, slow, hi, lo, gnd, idle, peak, zero;
  logic [2:0][6:0] ramp;
  typedef struct packed {logic [2:0] en; logic [2:0] de; logic bias; logic uvlo;
    logic [1:0] drv; logic [2:0] dis;} moss_row_t;
  moss_row_t rows [6] = '{'{3'h6, 3'h7, 1'b0, 1'b0, 2'h0, 3'h0},
    '{3'h4, 3'h5, 1'b1, 1'b0, 2'h1, 3'h5}, '{3'h0, 3'h7, 1'b1, 1'b0, 2'h2, 3'h0},
    '{3'h1, 3'h6, 1'b0, 1'b0, 2'h3, 3'h6}, '{3'h7, 3'h0, 1'b1, 1'b1, 2'h1, 3'h7},
    '{3'h5, 3'h2, 1'b0, 1'b0, 2'h1, 3'h2}};
  int error_cnt = 0;
  int comparisons = 0;
  always #5 clock = ~clock;
  moss_sequencer #(.FAULT_TIMEOUT_CYCLES(16'h00C8)) i_moss_sequencer (.clock(clock), .rst(rst),
    .target_voltage_code(tgt), .peak_current_limit(lim), .channel_enable_ctrl(en),
    .discharge_enable(de), .buck_select(buck), .gate_drive_strength(drv), .fault_clear(clr),
    .main_bias_on(bias), .supply_uvlo(uvlo), .below_target_cmp(below),
    .peak_current_cmp(peak), .zero_cross_detect(zero), .input_high_switch(hi),
    .input_low_switch(lo), .channel_output_switch(och), .output_ground_switch(gnd),
    .discharge_switch(dis), .gate_drive_level(drvl), .peak_limit_sel(psel),
    .ramp_target_code(ramp), .fault_flag(fault), .seq_idle(idle));
  moss_switch_stage_model i_moss_switch_stage_model (.clock(clock), .rst(rst),
    .input_high_switch(hi), .input_low_switch(lo), .demand(demand), .slow(slow),
    .peak_current_cmp(peak), .zero_cross_detect(zero), .below_target_cmp(below));
  task report_and_stop;
    if (error_cnt == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task check_val(input logic [6:0] got, input logic [6:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Phase 0 service start, 1 discharge, 2 back to idle
  task wait_for(input int ph);
    int n;
    logic hit;
    n = 0;
    hit = 1'b0;
    while (!hit && n < 400)
    begin
      case (ph)
        0: hit = idle === 1'b0;
        1: hit = lo === 1'b1;
        default: hit = idle === 1'b1;
      endcase
      if (!hit)
      begin
        @(negedge clock);
        n++;
      end
    end
    if (!hit)
    begin
      error_cnt++;
      report_and_stop();
    end
  endtask
  task serve(input int ch, input logic bk, input logic last);
    logic [2:0] oh;
    oh = 3'h1 << ch;
    wait_for(0);
    check_val(7'({hi, lo}), 7'h02);
    check_val(7'({gnd, och}), bk ? 7'(oh) : 7'h08);
    check_val(7'(psel), 7'(lim[ch]));
    wait_for(1);
    if (last)
      demand = 3'h0;
    check_val(7'({hi, gnd, och}), 7'(oh));
    wait_for(2);
    check_val(7'({hi, lo, gnd, och}), 7'h00);
  endtask
  task set_demand(input logic [2:0] d);
    repeat (24) @(negedge clock);
    check_val(7'({hi, lo, gnd, och, idle}), 7'h01);
    demand = d;
  endtask
  initial
  begin
    tgt = {7'h10, 7'h20, 7'h30};
    lim = {2'h3, 2'h1, 2'h0};
    en = 9'h000;
    de = 3'h0;
    buck = 3'h0;
    drv = 2'h1;
    clr = 3'h0;
    bias = 1'b0;
    uvlo = 1'b0;
    demand = 3'h0;
    slow = 1'b0;
    repeat (2) @(negedge clock);
    check_val(7'({hi, lo, gnd, och, idle}), 7'h01);
    check_val(7'({drvl, dis}), 7'h08);
    rst = 1'b0;
    foreach (rows[i])
    begin
      en = {3{rows[i].en}};
      de = rows[i].de;
      bias = rows[i].bias;
      uvlo = rows[i].uvlo;
      drv = rows[i].drv;
      repeat (6) @(negedge clock);
      check_val(7'(dis), 7'(rows[i].dis));
      check_val(7'({drvl, idle}), 7'({rows[i].drv, 1'b1}));
    end
    en = {3{3'h6}};
    de = 3'h0;
    uvlo = 1'b0;
    bias = 1'b1;
    set_demand(3'h1);
    serve(0, 1'b0, 1'b1);
    // Buck only on the output with enough input headroom
    buck = 3'h2;
    set_demand(3'h7);
    slow = 1'b1;
    serve(1, 1'b1, 1'b0);
    serve(2, 1'b0, 1'b0);
    serve(0, 1'b0, 1'b0);
    serve(1, 1'b1, 1'b1);
    slow = 1'b0;
    set_demand(3'h5);
    serve(2, 1'b0, 1'b0);
    serve(0, 1'b0, 1'b0);
    serve(2, 1'b0, 1'b1);
    set_demand(3'h0);
    en = {3{3'h4}};
    clr = 3'h7;
    tgt[2] = 7'h03;
    repeat (3) @(negedge clock);
    clr = 3'h0;
    check_val(7'({fault, ramp[0][3:0]}), 7'h00);
    en[2] = 3'h6;
    demand = 3'h4;
    repeat (10) @(negedge clock);
    check_val(ramp[2], 7'h00);
    repeat (20) @(negedge clock);
    check_val(ramp[2], 7'h01);
    repeat (60) @(negedge clock);
    check_val(ramp[2], 7'h03);
    repeat (100) @(negedge clock);
    check_val(7'(fault), 7'h00);
    repeat (20) @(negedge clock);
    check_val(7'(fault), 7'h04);
    demand = 3'h0;
    repeat (30) @(negedge clock);
    check_val(7'(fault), 7'h04);
    clr = 3'h4;
    @(negedge clock);
    clr = 3'h0;
    repeat (3) @(negedge clock);
    check_val(7'(fault), 7'h00);
    // Reset in mid-service opens every switch at once
    demand = 3'h4;
    wait_for(0);
    rst = 1'b1;
    @(negedge clock);
    check_val(7'({hi, lo, gnd, och, idle}), 7'h01);
    check_val(7'({fault, ramp[2][3:0]}), 7'h00);
    rst = 1'b0;
    demand = 3'h0;
    repeat (4) @(negedge clock);
    check_val(7'({hi, lo, gnd, och, idle}), 7'h01);
    report_and_stop();
  end
endmodule
`default_nettype wire
